// ===== trup_regs.svh
`ifndef TRUP_REGS_SVH
`define TRUP_REGS_SVH

// Register byte offsets on the AXI4-Lite port.
`define TRUP_OFF_CTRL      8'h00
`define TRUP_OFF_THRESH    8'h04
`define TRUP_OFF_TIMER     8'h08
`define TRUP_OFF_STATUS    8'h0c
`define TRUP_OFF_PKTCNT    8'h10

// Control register fields.
`define TRUP_CTRL_ECRC     0
`define TRUP_CTRL_B64_LO   1
`define TRUP_CTRL_B64_HI   3

// Status register fields.
`define TRUP_ST_INPKT      0
`define TRUP_ST_UR_NP      1
`define TRUP_ST_UR_P       2
`define TRUP_ST_MALF       3

// Reset values.
`define TRUP_CTRL_RST      4'h1
`define TRUP_THRESH_RST    8'h08
`define TRUP_TIMER_RST     16'h0400

// Encodings of a locked memory read in header byte 0.
`define TRUP_MRDLK_3DW     8'h01
`define TRUP_MRDLK_4DW     8'h21

`endif

// ===== trup_pkg.sv
package trup_pkg;

    // Credit classes in the order the scheduler scans them.
    typedef enum logic [1:0] {
        TRUP_CLS_PH,
        TRUP_CLS_PD,
        TRUP_CLS_NPH,
        TRUP_CLS_NPD
    } trup_cls_t;

    // Side-band qualifiers of one beat coming up from the link layer.
    typedef struct packed {
        logic       valid;
        logic       sop;
        logic       eop;
        logic       dwen;
        logic       ecrc_bad;
        logic       len_bad;
        logic [6:0] bar_match;
    } trup_beat_t;

    // Request for one UpdateFC DLLP.
    typedef struct packed {
        trup_cls_t   cls;
        logic [11:0] credits;
    } trup_fc_upd_t;

endpackage : trup_pkg

// ===== trup_rx_user_port.sv
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "trup_regs.svh"
module trup_rx_user_port #(
    parameter int WIDE   = 1,
    parameter int ECRC_EN = 1,
    parameter int BW     = (WIDE != 0) ? 8 : 2
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [31:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [31:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire trup_pkg::trup_beat_t lnk_beat,
    input  wire logic [BW-1:0][7:0]   lnk_bytes,
    output logic [BW*8-1:0]           recv_payload_bus,
    output logic                      recv_pkt_first,
    output logic                      recv_pkt_last,
    output logic                      recv_single_dword,
    output logic                      recv_crc_fail,
    output logic                      recv_unsupported_flag,
    output logic                      recv_malformed_flag,
    output logic [6:0]                recv_bar_hit,
    input  wire logic                 app_unsupported_nonposted,
    input  wire logic                 app_unsupported_posted,
    input  wire logic [3:0]           app_buffer_full,
    input  wire logic [1:0]           header_credit_return,
    input  wire logic [1:0]           data_credit_return_strobe,
    input  wire logic [1:0][7:0]      data_credit_return_count,
    output trup_pkg::trup_fc_upd_t    fc_upd,
    output logic                      fc_upd_valid,
    input  wire logic                 fc_upd_ready
);

    // ****************************************************************
    // Register bus slave
    // ****************************************************************

    logic [3:0]  ctrl_ff;
    logic [7:0]  thresh_ff;
    logic [15:0] timer_ff;
    logic [3:1]  sticky_ff;
    logic [31:0] pktcnt_ff;
    logic        in_pkt_ff;
    logic        aw_ff;
    logic        w_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        do_wr;
    logic [2:0]  b64;
    logic [31:0] nxt_rdata;
    logic        nxt_rerr;

    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr         = aw_ff && w_ff && !s_axi_bvalid;
    assign b64           = ctrl_ff[`TRUP_CTRL_B64_HI:`TRUP_CTRL_B64_LO];

    // Address and data may arrive in either order; each is parked here.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr[7:0];
            end else if (do_wr) begin
                aw_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (do_wr) begin
                w_ff <= 1'b0;
            end
        end
    end

    // Write response; an unmapped or read-only address answers SLVERR.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_ff == `TRUP_OFF_CTRL ||
                             awaddr_ff == `TRUP_OFF_THRESH ||
                             awaddr_ff == `TRUP_OFF_TIMER ||
                             awaddr_ff == `TRUP_OFF_STATUS) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Writable configuration, byte-lane masked.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff   <= `TRUP_CTRL_RST;
            thresh_ff <= `TRUP_THRESH_RST;
            timer_ff  <= `TRUP_TIMER_RST;
        end else if (do_wr) begin
            if (awaddr_ff == `TRUP_OFF_CTRL && wstrb_ff[0])
                ctrl_ff <= wdata_ff[3:0];
            if (awaddr_ff == `TRUP_OFF_THRESH && wstrb_ff[0])
                thresh_ff <= wdata_ff[7:0];
            if (awaddr_ff == `TRUP_OFF_TIMER) begin
                if (wstrb_ff[0])
                    timer_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1])
                    timer_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    // Read mux; the status word shows live and sticky block state.
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rerr  = 1'b0;
        case (s_axi_araddr[7:0])
            `TRUP_OFF_CTRL:   nxt_rdata[3:0]  = ctrl_ff;
            `TRUP_OFF_THRESH: nxt_rdata[7:0]  = thresh_ff;
            `TRUP_OFF_TIMER:  nxt_rdata[15:0] = timer_ff;
            `TRUP_OFF_STATUS: nxt_rdata[3:0]  = {sticky_ff, in_pkt_ff};
            `TRUP_OFF_PKTCNT: nxt_rdata       = pktcnt_ff;
            default:          nxt_rerr        = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= nxt_rdata;
            s_axi_rresp  <= nxt_rerr ? 2'b10 : 2'b00;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Receive TLP path
    // ****************************************************************

    logic [BW*8-1:0] nxt_payload;
    logic [6:0]      nxt_hit;
    logic            framing_bad;
    logic            locked_rd;

    // Byte 0 of the link beat is the earliest on the wire.
    always_comb begin
        nxt_payload = '0;
        for (int i = 0; i < BW; i++) begin
            nxt_payload[(BW-1-i)*8 +: 8] = lnk_bytes[i];
        end
    end

    // A paired 64-bit window reports only on its lower-numbered BAR.
    always_comb begin
        nxt_hit = lnk_beat.bar_match;
        for (int p = 0; p < 3; p++) begin
            if (b64[p]) begin
                nxt_hit[2*p]   = lnk_beat.bar_match[2*p] |
                                 lnk_beat.bar_match[2*p+1];
                nxt_hit[2*p+1] = 1'b0;
            end
        end
    end

    // A start inside a packet or data outside one is a format fault.
    assign framing_bad = lnk_beat.valid &&
                         (lnk_beat.sop ? in_pkt_ff : !in_pkt_ff);
    assign locked_rd   = lnk_beat.sop &&
                         (lnk_bytes[0] == `TRUP_MRDLK_3DW ||
                          lnk_bytes[0] == `TRUP_MRDLK_4DW);

    // Packet framing tracker.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_pkt_ff <= 1'b0;
            pktcnt_ff <= 32'h0000_0000;
        end else if (lnk_beat.valid) begin
            in_pkt_ff <= !lnk_beat.eop;
            if (lnk_beat.eop)
                pktcnt_ff <= pktcnt_ff + 32'h0000_0001;
        end
    end

    // One registered stage to the user; flags live on valid beats, except the unsupported flag, which is held for the whole packet.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            recv_payload_bus      <= '0;
            recv_pkt_first        <= 1'b0;
            recv_pkt_last         <= 1'b0;
            recv_single_dword     <= 1'b0;
            recv_crc_fail         <= 1'b0;
            recv_unsupported_flag <= 1'b0;
            recv_malformed_flag   <= 1'b0;
        end else begin
            if (lnk_beat.valid)
                recv_payload_bus <= nxt_payload;
            recv_pkt_first    <= lnk_beat.valid && lnk_beat.sop;
            recv_pkt_last     <= lnk_beat.valid && lnk_beat.eop;
            recv_single_dword <= (WIDE != 0) && lnk_beat.valid &&
                                 lnk_beat.dwen;
            recv_crc_fail     <= (ECRC_EN != 0) && ctrl_ff[`TRUP_CTRL_ECRC] &&
                                 lnk_beat.valid &&
                                 lnk_beat.ecrc_bad;
            if (lnk_beat.valid && lnk_beat.sop)
                recv_unsupported_flag <= locked_rd;
            else if (recv_pkt_last)
                recv_unsupported_flag <= 1'b0;
            recv_malformed_flag <= lnk_beat.valid &&
                                   (lnk_beat.len_bad || framing_bad);
        end
    end

    // Hit vector loads only on a first beat, so it tracks that TLP.
    always_ff @(posedge aclk) begin
        if (!aresetn)
            recv_bar_hit <= 7'h00;
        else if (lnk_beat.valid && lnk_beat.sop)
            recv_bar_hit <= nxt_hit;
    end

    // Sticky status; a new event in the clearing cycle wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sticky_ff <= 3'h0;
        end else begin
            for (int s = 1; s < 4; s++) begin
                if (do_wr && awaddr_ff == `TRUP_OFF_STATUS &&
                    wstrb_ff[0] && wdata_ff[s])
                    sticky_ff[s] <= 1'b0;
            end
            if (app_unsupported_nonposted)
                sticky_ff[`TRUP_ST_UR_NP] <= 1'b1;
            if (app_unsupported_posted)
                sticky_ff[`TRUP_ST_UR_P] <= 1'b1;
            if (lnk_beat.valid && (lnk_beat.len_bad || framing_bad))
                sticky_ff[`TRUP_ST_MALF] <= 1'b1;
        end
    end

    // ****************************************************************
    // Credit return and UpdateFC scheduling
    // ****************************************************************

    logic [3:0][7:0]  inc;
    logic [3:0][7:0]  acc_ff;
    logic [3:0][11:0] tot_ff;
    logic [3:0][15:0] tmr_ff;
    logic [3:0]       need;
    logic [3:0]       grant;
    logic             slot_free;

    // Header classes count cycles; data classes take the strobed count.
    assign inc[0] = {7'h00, header_credit_return[0]};
    assign inc[2] = {7'h00, header_credit_return[1]};
    assign inc[1] = data_credit_return_strobe[0] ?
                    data_credit_return_count[0] : 8'h00;
    assign inc[3] = data_credit_return_strobe[1] ?
                    data_credit_return_count[1] : 8'h00;
    assign slot_free = !fc_upd_valid || fc_upd_ready;

    // Lowest class with a reason to update goes first.
    always_comb begin
        grant = 4'h0;
        for (int c = 0; c < 4; c++) begin
            need[c] = app_buffer_full[c] ||
                      (acc_ff[c] != 8'h00 && acc_ff[c] >= thresh_ff) ||
                      tmr_ff[c] >= timer_ff;
        end
        for (int c = 3; c >= 0; c--) begin
            if (need[c] && slot_free)
                grant = 4'(1 << c);
        end
    end

    // Per-class pending credits, running total and refresh timer.
    // Credits landing in the grant cycle are kept for the next update.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_ff <= '0;
            tot_ff <= '0;
            tmr_ff <= '0;
        end else begin
            for (int c = 0; c < 4; c++) begin
                tot_ff[c] <= tot_ff[c] + {4'h0, inc[c]};
                if (grant[c]) begin
                    acc_ff[c] <= inc[c];
                    tmr_ff[c] <= 16'h0000;
                end else begin
                    acc_ff[c] <= (acc_ff[c] > 8'hff - inc[c]) ?
                                 8'hff : acc_ff[c] + inc[c];
                    if (tmr_ff[c] != 16'hffff)
                        tmr_ff[c] <= tmr_ff[c] + 16'h0001;
                end
            end
        end
    end

    // Output slot toward the DLLP transmitter.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fc_upd_valid <= 1'b0;
            fc_upd       <= '0;
        end else if (grant != 4'h0) begin
            fc_upd_valid <= 1'b1;
            for (int c = 0; c < 4; c++) begin
                if (grant[c]) begin
                    fc_upd.cls     <= trup_pkg::trup_cls_t'(c[1:0]);
                    fc_upd.credits <= tot_ff[c] + {4'h0, inc[c]};
                end
            end
        end else if (fc_upd_ready) begin
            fc_upd_valid <= 1'b0;
        end
    end

endmodule : trup_rx_user_port

// ===== trup_rx_assertions.sv
`timescale 1ns/1ps
// ******
// Receive path and UpdateFC checker
// ******
module trup_rx_checker #(
    parameter int WIDE    = 1,
    parameter int ECRC_EN = 1,
    parameter int BW      = 8
) (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire trup_pkg::trup_beat_t   lnk_beat,
    input wire logic [BW-1:0][7:0]     lnk_bytes,
    input wire logic [BW*8-1:0]        recv_payload_bus,
    input wire logic                   recv_pkt_first,
    input wire logic                   recv_pkt_last,
    input wire logic                   recv_single_dword,
    input wire logic                   recv_crc_fail,
    input wire logic                   recv_unsupported_flag,
    input wire logic                   recv_malformed_flag,
    input wire logic [6:0]             recv_bar_hit,
    input wire logic [3:0]             app_buffer_full,
    input wire logic                   fc_upd_valid,
    input wire trup_pkg::trup_fc_upd_t fc_upd,
    input wire logic                   fc_upd_ready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Each receive output follows its beat by one cycle.
    a_first_on_sop: assert property (
        lnk_beat.valid && lnk_beat.sop |=> recv_pkt_first)
        else $error("first flag missing");
    a_first_cause: assert property (
        recv_pkt_first |-> $past(lnk_beat.valid && lnk_beat.sop))
        else $error("first flag without cause");
    a_last_on_eop: assert property (
        lnk_beat.valid && lnk_beat.eop |=> recv_pkt_last)
        else $error("last flag missing");
    a_byte_order: assert property (
        lnk_beat.valid |=> recv_payload_bus[BW*8-1 -: 8] == $past(lnk_bytes[0]))
        else $error("earliest byte not in top lane");
    a_dword_flag: assert property (
        lnk_beat.valid |=> recv_single_dword == (WIDE != 0 && $past(lnk_beat.dwen)))
        else $error("single dword flag wrong");
    a_crc_cause: assert property (
        recv_crc_fail |-> ECRC_EN != 0 && $past(lnk_beat.valid && lnk_beat.ecrc_bad))
        else $error("crc flag without cause");
    a_locked_read: assert property (
        lnk_beat.valid && lnk_beat.sop
        && (lnk_bytes[0] == 8'h01 || lnk_bytes[0] == 8'h21)
        |=> recv_unsupported_flag && recv_pkt_first)
        else $error("locked read not flagged");
    a_malf_len: assert property (
        lnk_beat.valid && lnk_beat.len_bad |=> recv_malformed_flag)
        else $error("malformed flag missing");
    a_bar_steady: assert property (
        !recv_pkt_first |-> $stable(recv_bar_hit))
        else $error("hit vector moved without first flag");
    a_fc_holds: assert property (
        fc_upd_valid && !fc_upd_ready |=> fc_upd_valid && $stable(fc_upd))
        else $error("update dropped before taken");
    a_full_prompt: assert property (
        |app_buffer_full && (!fc_upd_valid || fc_upd_ready) |=> fc_upd_valid)
        else $error("buffer full gave no prompt update");

    c_one_beat: cover property (recv_pkt_first && recv_pkt_last);
    c_fc_stall: cover property (fc_upd_valid && !fc_upd_ready);
    c_locked: cover property (recv_unsupported_flag && recv_pkt_last);
endmodule : trup_rx_checker

bind trup_rx_user_port trup_rx_checker #(
    .WIDE(WIDE), .ECRC_EN(ECRC_EN), .BW(BW)
) i_trup_rx_checker (
    .aclk, .aresetn, .lnk_beat, .lnk_bytes, .recv_payload_bus,
    .recv_pkt_first, .recv_pkt_last, .recv_single_dword, .recv_crc_fail,
    .recv_unsupported_flag, .recv_malformed_flag, .recv_bar_hit,
    .app_buffer_full, .fc_upd_valid, .fc_upd, .fc_upd_ready
);

// ===== trup_app_model.sv
`timescale 1ns/1ps
// ******
// Application side model
// ******
module trup_app_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic slow,
    input  wire logic recv_pkt_last,
    input  wire logic recv_unsupported_flag,
    input  wire logic fc_upd_valid,
    output logic      fc_upd_ready,
    output logic      hdr_ret,
    output logic      ur_np
);
    logic [1:0] cnt_ff;

    // One posted header credit goes back per consumed packet.
    always_ff @(posedge aclk) begin
        hdr_ret <= aresetn && recv_pkt_last;
        ur_np   <= aresetn && recv_pkt_last && recv_unsupported_flag;
    end

    // A slow consumer is ready one cycle in four.
    always_ff @(posedge aclk) begin
        cnt_ff <= aresetn ? cnt_ff + 2'h1 : 2'h0;
    end
    assign fc_upd_ready = !slow || (fc_upd_valid && cnt_ff == 2'h3);
endmodule : trup_app_model

// ===== trup_rx_user_port_tb.sv
`timescale 1ns/1ps
`include "trup_regs.svh"
module trup_rx_user_port_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, mf;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, slow;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, nph_ret, vd;
    logic recv_pkt_first, recv_pkt_last, recv_single_dword, recv_crc_fail;
    logic recv_unsupported_flag, recv_malformed_flag, fc_upd_valid;
    logic app_unsupported_posted;
    wire logic hdr_ret, app_unsupported_nonposted, fc_upd_ready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, app_buffer_full, ctrl;
    logic [1:0]  s_axi_bresp, s_axi_rresp, data_credit_return_strobe;
    logic [1:0][7:0] data_credit_return_count;
    logic [7:0][7:0] lnk_bytes;
    logic [63:0] recv_payload_bus;
    logic [6:0]  recv_bar_hit, hx;
    logic [76:0] bq[$], fq[$], rq[$];
    int          n_fail, n_compared, seed, npk, k;
    trup_pkg::trup_beat_t   lnk_beat;
    trup_pkg::trup_fc_upd_t fc_upd;

    trup_rx_user_port i_trup_rx_user_port (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .lnk_beat, .lnk_bytes,
        .recv_payload_bus, .recv_pkt_first, .recv_pkt_last,
        .recv_single_dword, .recv_crc_fail, .recv_unsupported_flag,
        .recv_malformed_flag, .recv_bar_hit, .app_unsupported_nonposted,
        .app_unsupported_posted, .app_buffer_full,
        .header_credit_return({nph_ret, hdr_ret}),
        .data_credit_return_strobe, .data_credit_return_count,
        .fc_upd, .fc_upd_valid, .fc_upd_ready);

    trup_app_model i_trup_app_model (.aclk, .aresetn, .slow, .recv_pkt_last,
        .recv_unsupported_flag, .fc_upd_valid, .fc_upd_ready, .hdr_ret,
        .ur_np(app_unsupported_nonposted));

    // ******
    // Clock, comparison and verdict
    // ******
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic note(input logic [76:0] g, e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : note
    task automatic cmp_beat(input logic [76:0] g, e);
        note(g, e);
    endtask : cmp_beat
    task automatic cmp_fc(input logic [76:0] g, e);
        note(g, e);
    endtask : cmp_fc
    task automatic cmp_reg(input logic [76:0] g, e);
        note(g, e);
    endtask : cmp_reg

    task automatic print_verdict;
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // Results are judged mid-cycle, once outputs have settled.
    always @(posedge aclk) vd <= lnk_beat.valid;
    always @(negedge aclk) begin
        if (vd && aresetn)
            cmp_beat({recv_payload_bus, recv_pkt_first, recv_pkt_last,
                recv_single_dword, recv_crc_fail, recv_unsupported_flag,
                recv_malformed_flag, recv_bar_hit}, bq.pop_front());
        if (fc_upd_valid && fc_upd_ready)
            cmp_fc({63'h0, fc_upd}, fq.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            cmp_reg({43'h0, s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            cmp_reg({43'h0, s_axi_bresp, 32'h0}, rq.pop_front());
    end

    // ******
    // Drivers
    // ******
    // Handshakes are seen at the falling edge, released at the rising.
    task automatic axi(input logic w_en, input logic [7:0] a,
                       input logic [31:0] d, input logic [1:0] r);
        logic ha, hw, hr;
        int   i;
        hr = 1'b0;
        rq.push_back({43'h0, r, w_en ? 32'h0 : d});
        if (w_en) begin
            s_axi_awaddr  <= {24'h0, a};
            s_axi_wdata   <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
        end else begin
            s_axi_araddr  <= {24'h0, a};
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
        end
        for (i = 0; i < 40 && !hr; i++) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
            hw = s_axi_wvalid && s_axi_wready;
            hr = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
            @(posedge aclk);
            if (ha) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hr) {s_axi_bready, s_axi_rready} <= 2'h0;
        end
        @(posedge aclk);
        if (!hr) n_fail++;
        if (!hr) print_verdict;
    endtask : axi

    task automatic drain;
        int i;
        for (i = 0; i < 200 && fq.size() + bq.size() > 0; i++) @(posedge aclk);
        if (i == 200) n_fail++;
        if (i == 200) print_verdict;
    endtask : drain

    // A 64-bit pair reports its hit on its lower BAR only.
    function automatic logic [6:0] fold(input logic [6:0] m);
        fold = m;
        for (int j = 0; j < 3; j++) begin
            if (ctrl[j+1]) fold[2*j] = m[2*j] | m[2*j+1];
            if (ctrl[j+1]) fold[2*j+1] = 1'b0;
        end
    endfunction : fold

    task automatic send_pkt(input int n, input logic [7:0] code);
        trup_pkg::trup_beat_t b;
        logic [7:0][7:0]      by;
        logic [63:0]          p;
        logic                 ur;
        int                   i, j;
        ur = code == 8'h01 || code == 8'h21;
        for (i = 0; i < n; i++) begin
            b = 13'($random(seed));
            by = {$random(seed), $random(seed)};
            b.valid = 1'b1;
            b.sop = i == 0;
            b.eop = i == n - 1;
            if (i == 0) by[0] = code;
            if (i == 0) hx = fold(b.bar_match);
            for (j = 0; j < 8; j++) p[63-8*j -: 8] = by[j];
            mf = mf | b.len_bad;
            bq.push_back({p, b.sop, b.eop, b.dwen, b.ecrc_bad & ctrl[0],
                ur, b.len_bad, hx});
            lnk_beat  <= b;
            lnk_bytes <= by;
            @(posedge aclk);
        end
        npk++;
        if (npk % 2 == 1) return;
        fq.push_back({63'h0, 2'h0, 12'(npk)});
        lnk_beat.valid <= 1'b0; // A gap keeps returns off the grant.
        @(posedge aclk);
    endtask : send_pkt

    // Data credits: strobe and buffer-full stand for one cycle; the count is held.
    task automatic pulse(input logic [3:0] bf, input logic [1:0] s,
                         input logic [7:0] c, input logic [13:0] e);
        if (e != 14'h0) fq.push_back({63'h0, e});
        app_buffer_full           <= bf;
        data_credit_return_strobe <= s;
        data_credit_return_count  <= {c, c};
        @(posedge aclk);
        app_buffer_full           <= 4'h0;
        data_credit_return_strobe <= 2'h0;
        @(posedge aclk);
        drain;
    endtask : pulse

    // ******
    // Main sequence
    // ******
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, slow, nph_ret, app_unsupported_posted, mf} = 5'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {app_buffer_full, data_credit_return_strobe} = 6'h0;
        data_credit_return_count = 16'h0;
        s_axi_wstrb = 4'hf;
        lnk_beat = 13'h0;
        lnk_bytes = 64'h0;
        {n_fail, n_compared, npk, seed} = {96'h0, 32'd9103};
        aresetn = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi(1'b0, `TRUP_OFF_CTRL, 32'(`TRUP_CTRL_RST), 2'h0);
        axi(1'b0, `TRUP_OFF_THRESH, 32'(`TRUP_THRESH_RST), 2'h0);
        axi(1'b0, `TRUP_OFF_TIMER, 32'(`TRUP_TIMER_RST), 2'h0);
        axi(1'b0, 8'h14, 32'h0, 2'h2);
        axi(1'b1, `TRUP_OFF_PKTCNT, 32'h5, 2'h2);
        axi(1'b1, `TRUP_OFF_TIMER, 32'hffff, 2'h0);
        axi(1'b1, `TRUP_OFF_THRESH, 32'h2, 2'h0);
        // Each setting of ECRC check and BAR pairing sees every header code.
        for (k = 0; k < 12; k++) begin
            if (k % 4 == 0) ctrl = (k == 0) ? 4'h1 : (k == 4) ? 4'hf : 4'h0;
            if (k % 4 == 0) axi(1'b1, `TRUP_OFF_CTRL, {28'h0, ctrl}, 2'h0);
            send_pkt(k % 3 + 1, (k % 4 == 0) ? 8'h01 : (k % 4 == 1) ? 8'h21 :
                     (k % 4 == 2) ? 8'h40 : 8'h60);
        end
        drain;
        slow <= 1'b1;
        pulse(4'h0, 2'b01, 8'h05, {2'h1, 12'h005});
        pulse(4'h0, 2'b10, 8'hff, {2'h3, 12'h0ff});
        pulse(4'h0, 2'b01, 8'h01, 14'h0);
        pulse(4'b0010, 2'b00, 8'h00, {2'h1, 12'h006});
        pulse(4'b0001, 2'b00, 8'h00, {2'h0, 12'h00c});
        fq.push_back({63'h0, 2'h2, 12'h002});
        nph_ret <= 1'b1;
        repeat (2) @(posedge aclk);
        nph_ret <= 1'b0;
        app_unsupported_posted <= 1'b1;
        @(posedge aclk);
        app_unsupported_posted <= 1'b0;
        drain;
        // Sticky status: both unsupported bits, malformed if seen.
        axi(1'b0, `TRUP_OFF_STATUS, {28'h0, mf, 3'b110}, 2'h0);
        axi(1'b1, `TRUP_OFF_STATUS, 32'hf, 2'h0);
        axi(1'b0, `TRUP_OFF_STATUS, 32'h0, 2'h0);
        repeat (4) @(posedge aclk);
        print_verdict;
    end
endmodule : trup_rx_user_port_tb
